/* hw/wdpmt_map.svh */
`ifndef WDPMT_MAP_SVH
`define WDPMT_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define WDPMT_BASE_ADDR     32'h80002800
`define WDPMT_LAST_ADDR     32'h80002BFF
`define WDPMT_STATUS_ADDR   32'h80002800
`define WDPMT_CTRL_ADDR     32'h80002804
`define WDPMT_COUNT_ADDR    32'h80002808
`define WDPMT_PRESC_ADDR    32'h8000280C
`define WDPMT_MACT_ADDR     32'h80002814
`define WDPMT_MATCH0_ADDR   32'h80002818
`define WDPMT_MATCH1_ADDR   32'h8000281C
`define WDPMT_EXTM_ADDR     32'h8000283C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDPMT_ST_M0_BIT     0
`define WDPMT_ST_M1_BIT     1
`define WDPMT_CT_EN_BIT     0
`define WDPMT_CT_CLR_BIT    1
`define WDPMT_MA_ST0_BIT    0
`define WDPMT_MA_RST0_BIT   1
`define WDPMT_MA_STOP0_BIT  2
`define WDPMT_MA_ST1_BIT    3
`define WDPMT_MA_RST1_BIT   4
`define WDPMT_MA_STOP1_BIT  5
`define WDPMT_EM_OUT0_BIT   0
`define WDPMT_EM_INT_HI     5
`define WDPMT_EM_INT_LO     4
`define WDPMT_EM_INT_ON     2'h2
`define WDPMT_EM_RST_BIT    7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WDPMT_RST_ZERO32    32'h00000000
`define WDPMT_RST_ZERO2     2'h0
`define WDPMT_RST_ZERO6     6'h00
`define WDPMT_RST_ZERO3     3'h0

`endif

/* hw/wdpmt_pkg.sv */
package wdpmt_pkg;
   typedef logic [31:0] wdpmt_word_t;
   typedef enum logic [1:0] {
      WDPMT_ACC_IDLE  = 2'b00,
      WDPMT_ACC_WRITE = 2'b01,
      WDPMT_ACC_READ  = 2'b10
   } wdpmt_acc_e;
endpackage

/* hw/wdpmt_prescaler.sv */
`timescale 1ns/1ps
`include "wdpmt_map.svh"
module wdpmt_prescaler #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic             run,
   input  wire logic             hold_clear,
   input  wire logic [WIDTH-1:0] limit,
   output logic                  tick
);
   import wdpmt_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] count;
   } wdpmt_psc_s;

   wdpmt_psc_s st_reg;
   wdpmt_psc_s st_next;

   // Tick is combinational toward the main counter in the same edge
   assign tick = run && !hold_clear && (st_reg.count == limit);

   always_comb begin
      st_next = st_reg;
      if (hold_clear) begin
         st_next.count = '0;
      end else if (run) begin
         if (st_reg.count == limit) begin
            st_next.count = '0;
         end else begin
            st_next.count = st_reg.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_reg.count <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule // wdpmt_prescaler

/* hw/wdpmt_top.sv */
`timescale 1ns/1ps
`include "wdpmt_map.svh"
module wdpmt_top #(
   parameter int WIDTH = 32
) (
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   input  wire logic              bus_sel,
   input  wire logic              bus_write,
   input  wire wdpmt_pkg::wdpmt_word_t bus_addr,
   input  wire wdpmt_pkg::wdpmt_word_t bus_wdata,
   output wdpmt_pkg::wdpmt_word_t bus_rdata,
   output logic                   bus_rvalid,
   output logic                   interrupt_match_out,
   output logic                   reset_match_out
);
   import wdpmt_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [1:0]       status;
      logic [1:0]       ctrl;
      logic [WIDTH-1:0] count;
      logic [WIDTH-1:0] limit;
      logic [5:0]       mact;
      logic [WIDTH-1:0] match0;
      logic [WIDTH-1:0] match1;
      logic [2:0]       extm;
      logic             out0;
      logic             out1;
      wdpmt_word_t      rdata;
      logic             rvalid;
   } wdpmt_top_s;

   wdpmt_top_s st_reg;
   wdpmt_top_s st_next;
   logic       tick;
   logic       hit0;
   logic       hit1;
   wdpmt_acc_e acc;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic addr_is(input wdpmt_word_t a, input wdpmt_word_t r);
      addr_is = (a == r);
   endfunction

   assign acc = !bus_sel ? WDPMT_ACC_IDLE : (bus_write ? WDPMT_ACC_WRITE : WDPMT_ACC_READ);

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   wdpmt_prescaler #(
      .WIDTH (WIDTH)
   ) u_presc (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .run        (st_reg.ctrl[`WDPMT_CT_EN_BIT]),
      .hold_clear (st_reg.ctrl[`WDPMT_CT_CLR_BIT]),
      .limit      (st_reg.limit),
      .tick       (tick)
   );

   // Compare at each edge against current count
   assign hit0 = (st_reg.count == st_reg.match0);
   assign hit1 = (st_reg.count == st_reg.match1);

   always_comb begin
      st_next        = st_reg;
      st_next.rvalid = 1'b0;

      // ----------------------------------------
      // Counter
      // ----------------------------------------
      if (st_reg.ctrl[`WDPMT_CT_CLR_BIT]) begin
         st_next.count = '0;
      end else if ((hit0 && st_reg.mact[`WDPMT_MA_RST0_BIT]) ||
                   (hit1 && st_reg.mact[`WDPMT_MA_RST1_BIT])) begin
         st_next.count = '0;
      end else if (tick) begin
         st_next.count = st_reg.count + 1'b1;
      end

      // Match outputs: registered levels, one cycle after equal and enabled
      st_next.out0 = hit0 && (st_reg.extm[2:1] == `WDPMT_EM_INT_ON);
      st_next.out1 = hit1 && st_reg.extm[0];

      // ----------------------------------------
      // Register writes
      // ----------------------------------------
      if (acc == WDPMT_ACC_WRITE) begin
         if (addr_is(bus_addr, `WDPMT_STATUS_ADDR)) begin
            st_next.status = st_reg.status & ~bus_wdata[1:0];
         end else if (addr_is(bus_addr, `WDPMT_CTRL_ADDR)) begin
            st_next.ctrl = bus_wdata[1:0];
         end else if (addr_is(bus_addr, `WDPMT_COUNT_ADDR)) begin
            st_next.count = bus_wdata[WIDTH-1:0];
         end else if (addr_is(bus_addr, `WDPMT_PRESC_ADDR)) begin
            st_next.limit = bus_wdata[WIDTH-1:0];
         end else if (addr_is(bus_addr, `WDPMT_MACT_ADDR)) begin
            st_next.mact = bus_wdata[5:0];
         end else if (addr_is(bus_addr, `WDPMT_MATCH0_ADDR)) begin
            st_next.match0 = bus_wdata[WIDTH-1:0];
         end else if (addr_is(bus_addr, `WDPMT_MATCH1_ADDR)) begin
            st_next.match1 = bus_wdata[WIDTH-1:0];
         end else if (addr_is(bus_addr, `WDPMT_EXTM_ADDR)) begin
            st_next.extm = {bus_wdata[`WDPMT_EM_INT_HI:`WDPMT_EM_INT_LO],
                            bus_wdata[`WDPMT_EM_RST_BIT]};
         end
      end

      // Hardware set wins over same-cycle clear
      if (hit0 && st_reg.mact[`WDPMT_MA_ST0_BIT]) begin
         st_next.status[`WDPMT_ST_M0_BIT] = 1'b1;
      end
      if (hit1 && st_reg.mact[`WDPMT_MA_ST1_BIT]) begin
         st_next.status[`WDPMT_ST_M1_BIT] = 1'b1;
      end
      if ((hit0 && st_reg.mact[`WDPMT_MA_STOP0_BIT]) ||
          (hit1 && st_reg.mact[`WDPMT_MA_STOP1_BIT])) begin
         st_next.ctrl[`WDPMT_CT_EN_BIT] = 1'b0;
      end

      // ----------------------------------------
      // Register reads, one full word per cycle
      // ----------------------------------------
      if (acc == WDPMT_ACC_READ) begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = `WDPMT_RST_ZERO32;
         if (addr_is(bus_addr, `WDPMT_STATUS_ADDR)) begin
            st_next.rdata[1:0] = st_reg.status;
         end else if (addr_is(bus_addr, `WDPMT_CTRL_ADDR)) begin
            st_next.rdata[1:0] = st_reg.ctrl;
         end else if (addr_is(bus_addr, `WDPMT_COUNT_ADDR)) begin
            st_next.rdata[WIDTH-1:0] = st_reg.count;
         end else if (addr_is(bus_addr, `WDPMT_PRESC_ADDR)) begin
            st_next.rdata[WIDTH-1:0] = st_reg.limit;
         end else if (addr_is(bus_addr, `WDPMT_MACT_ADDR)) begin
            st_next.rdata[5:0] = st_reg.mact;
         end else if (addr_is(bus_addr, `WDPMT_MATCH0_ADDR)) begin
            st_next.rdata[WIDTH-1:0] = st_reg.match0;
         end else if (addr_is(bus_addr, `WDPMT_MATCH1_ADDR)) begin
            st_next.rdata[WIDTH-1:0] = st_reg.match1;
         end else if (addr_is(bus_addr, `WDPMT_EXTM_ADDR)) begin
            st_next.rdata[`WDPMT_EM_INT_HI:`WDPMT_EM_INT_LO] = st_reg.extm[2:1];
            st_next.rdata[`WDPMT_EM_RST_BIT]               = st_reg.extm[0];
            st_next.rdata[`WDPMT_EM_OUT0_BIT]              = st_reg.out0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_reg.status <= `WDPMT_RST_ZERO2;
         st_reg.ctrl   <= `WDPMT_RST_ZERO2;
         st_reg.count  <= '0;
         st_reg.limit  <= '0;
         st_reg.mact   <= `WDPMT_RST_ZERO6;
         st_reg.match0 <= '0;
         st_reg.match1 <= '0;
         st_reg.extm   <= `WDPMT_RST_ZERO3;
         st_reg.out0   <= 1'b0;
         st_reg.out1   <= 1'b0;
         st_reg.rdata  <= `WDPMT_RST_ZERO32;
         st_reg.rvalid <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus_rdata           = st_reg.rdata;
   assign bus_rvalid          = st_reg.rvalid;
   assign interrupt_match_out = st_reg.out0;
   assign reset_match_out     = st_reg.out1;
endmodule // wdpmt_top

/* testbench/tb.sv */
`timescale 1ns/1ps
`include "wdpmt_map.svh"
module tb;
   import wdpmt_pkg::*;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic        bus_sel = 1'b0;
   logic        bus_write = 1'b0;
   wdpmt_word_t bus_addr = 32'h0;
   wdpmt_word_t bus_wdata = 32'h0;
   wdpmt_word_t bus_rdata;
   logic        bus_rvalid;
   logic        interrupt_match_out;
   logic        reset_match_out;
   int          irq_events;
   int          chip_resets;
   int          miscompares = 0;
   int          tests_run = 0;
   int          seed = 92;
   wdpmt_word_t rd;
   wdpmt_word_t a;
   wdpmt_word_t regs[8] = '{`WDPMT_STATUS_ADDR, `WDPMT_CTRL_ADDR, `WDPMT_COUNT_ADDR,
      `WDPMT_PRESC_ADDR, `WDPMT_MACT_ADDR, `WDPMT_MATCH0_ADDR, `WDPMT_MATCH1_ADDR,
      `WDPMT_EXTM_ADDR};
   always #2.5 clk_sys = ~clk_sys;
   wdpmt_top wdpmt_top_i (.*);
   wdpmt_far_model wdpmt_far_model_i (.*);
   // ----
   // Bus tasks
   // ----
   task chk(input wdpmt_word_t seen, input wdpmt_word_t exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task acc(input logic w, input wdpmt_word_t ad, input wdpmt_word_t d);
      @(negedge clk_sys);
      bus_sel = 1'b1;
      bus_write = w;
      bus_addr = ad;
      bus_wdata = d;
      @(negedge clk_sys);
      bus_sel = 1'b0;
      rd = bus_rdata;
      if (!w) chk({31'h0, bus_rvalid}, 32'h1);
   endtask
   task wr(input int i, input wdpmt_word_t d);
      acc(1'b1, regs[i], d);
   endtask
   task rdchk(input int i, input wdpmt_word_t exp);
      acc(1'b0, regs[i], 32'h0);
      chk(rd, exp);
   endtask
   task conclude;
      $display("counts: %0d compares, %0d mismatches", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #50000;
      miscompares++;
      conclude();
   end
   // ----
   // Scenarios
   // ----
   initial begin
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys) resetn = 1'b1;
      for (int i = 0; i < 8; i++) rdchk(i, 32'h0);
      acc(1'b0, 32'h80002BFC, 32'h0);
      chk(rd, 32'h0);
      acc(1'b0, 32'h80002810, 32'h0);
      chk(rd, 32'h0);
      for (int i = 3; i < 7; i++) begin
         a = $random(seed);
         if (i == 4) a = a & 32'h3F;
         wr(i, a);
         rdchk(i, a);
      end
      // Random actions matched the zero count above; drop them and their status
      wr(4, 32'h0);
      wr(0, 32'h3);
      rdchk(0, 32'h0);
      $display("test registers done");
      for (int l = 0; l < 4; l += 3) begin
         wr(3, l);
         wr(1, 32'h1);
         acc(1'b0, regs[2], 32'h0);
         a = rd;
         repeat (4 * (l + 1) - 2) @(negedge clk_sys);
         acc(1'b0, regs[2], 32'h0);
         chk(rd - a, 32'h4);
      end
      wr(1, 32'h0);
      acc(1'b0, regs[2], 32'h0);
      a = rd;
      repeat (5) @(negedge clk_sys);
      rdchk(2, a);
      wr(1, 32'h3);
      repeat (3) @(negedge clk_sys);
      rdchk(2, 32'h0);
      wr(1, 32'h0);
      wr(2, 32'd100);
      rdchk(2, 32'd100);
      $display("test counting done");
      wr(3, 32'h0);
      for (int k = 0; k < 2; k++) begin
         wr(2, 32'h0);
         wr(5 + k, 32'd20);
         wr(4, k ? 32'h38 : 32'h07);
         wr(7, k ? 32'h80 : 32'h20);
         wr(1, 32'h1);
         for (int n = 0; n < 200 && !(k ? reset_match_out : interrupt_match_out); n++)
            @(negedge clk_sys);
         repeat (3) @(negedge clk_sys);
         rdchk(0, 32'h1 << k);
         rdchk(1, 32'h0);
         rdchk(2, 32'h0);
         rdchk(7, k ? 32'h80 : 32'h20);
         wr(0, 32'h0);
         rdchk(0, 32'h1 << k);
         wr(0, 32'h1 << k);
         rdchk(0, 32'h0);
         chk(irq_events, 32'h1);
         chk(chip_resets, k);
      end
      $display("test matches done");
      @(negedge clk_sys) resetn = 1'b0;
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      for (int i = 0; i < 8; i++) rdchk(i, 32'h0);
      $display("test reset done");
      conclude();
   end
endmodule // tb

/* testbench/wdpmt_far_model.sv */
`timescale 1ns/1ps
module wdpmt_far_model (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic interrupt_match_out,
   input  wire logic reset_match_out,
   output int        irq_events,
   output int        chip_resets
);
   logic irq_q;
   logic rst_q;
   // ----
   // Event router and reset unit edge counters
   // ----
   always_ff @(posedge clk_sys) begin
      irq_q <= interrupt_match_out;
      rst_q <= reset_match_out;
      if (!resetn) begin
         irq_events <= 0;
         chip_resets <= 0;
      end else begin
         if (interrupt_match_out && !irq_q) irq_events <= irq_events + 1;
         if (reset_match_out && !rst_q) chip_resets <= chip_resets + 1;
      end
   end
endmodule // wdpmt_far_model

/* testbench/wdpmt_top_chk.sv */
`timescale 1ns/1ps
`include "wdpmt_map.svh"
module wdpmt_top_chk (
   input wire logic                   clk_sys,
   input wire logic                   resetn,
   input wire logic                   bus_sel,
   input wire logic                   bus_write,
   input wire wdpmt_pkg::wdpmt_word_t bus_addr,
   input wire wdpmt_pkg::wdpmt_word_t bus_wdata,
   input wire wdpmt_pkg::wdpmt_word_t bus_rdata,
   input wire logic                   bus_rvalid,
   input wire logic                   interrupt_match_out,
   input wire logic                   reset_match_out
);
   import wdpmt_pkg::*;
   // ----
   // Port checks
   // ----
   logic rd;
   assign rd = bus_sel && !bus_write;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   AST_RVALID: assert property (rd |=> bus_rvalid) else $error("read unanswered");
   AST_NO_RVALID: assert property (!rd |=> !bus_rvalid) else $error("stray rvalid");
   AST_RESET: assert property (@(posedge clk_sys) disable iff (1'b0) !resetn |=>
      !bus_rvalid && !interrupt_match_out && !reset_match_out) else $error("reset outs");
   AST_UNMAPPED: assert property (rd && bus_addr == 32'h80002810 |=>
      bus_rdata == 32'h0) else $error("unmapped read");
   AST_ST_RSVD: assert property (rd && bus_addr == `WDPMT_STATUS_ADDR |=>
      bus_rdata[31:2] == 30'h0) else $error("status spare bits");
   AST_CT_RSVD: assert property (rd && bus_addr == `WDPMT_CTRL_ADDR |=>
      bus_rdata[31:2] == 30'h0) else $error("control spare bits");
   AST_MA_RSVD: assert property (rd && bus_addr == `WDPMT_MACT_ADDR |=>
      bus_rdata[31:6] == 26'h0) else $error("action spare bits");
   AST_EXT_BIT0: assert property (rd && bus_addr == `WDPMT_EXTM_ADDR |=>
      bus_rdata[0] == $past(interrupt_match_out)) else $error("ext bit0");
endmodule // wdpmt_top_chk
bind wdpmt_top wdpmt_top_chk wdpmt_top_chk_i (.*);
